/* verilog/aimc_top.sv */
// Amplifier configuration register bank with APB slave, lock and timer-driven input switching
//
// Contract
// (RL1) Secondary non-inverting selector in bits 19:17, coded like the primary one.
// (RL2) Secondary inverting selector in bits 15:14, coded like the primary one.
// (RL3) Bit 13 enables timer-driven switching; when clear the primary selections stay.
// (RL4) Bits 11:9 route one of seven pins, codes 0 to 6, to non-inverting input.
// (RL5) Bits 7:6 route one of four pins to the inverting input.
// (RL6) Bits 5:3 give gain 2, 4, 8, 16, 32; other codes give 2.
// (RL7) Bits 2:1: upper bit 0 external, 10 internal gain, 11 follower.
// (RL8) Lock bit accepts one write after reset; later writes ignored until reset.
// (RL9) While locked the control word ignores writes; unlocked it is read/write.
// (RL10) Software writes reserved control bits 31:20, 16, 12, 8 with zero.
// (RL11) With switching on, compare-6 high selects secondary, otherwise primary.
// (RL12) Follower mode ties inverting input to output, whatever pin is selected.
// (RL13) Bit 0 powers the amplifier; locked writes complete without error.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "aimc_params.svh"
module aimc_top
  import aimc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              timer_compare6_signal,
  output var  logic              amp_enable,
  output var  logic [1:0]        amp_mode,
  output var  logic [6:0]        noninv_pin_onehot,
  output var  logic [3:0]        inv_pin_onehot,
  output var  logic              inv_to_output,
  output var  logic [5:0]        gain_factor,
  output var  logic              amp_cfg_locked
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0] amp_control_word_r;
  logic [31:0] amp_control_word_nxt;
  logic        config_write_lock_r;
  logic        lock_used_r;
  logic        cc6_meta_r;
  logic        cc6_sync_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        chk_arm_r;

  aimc_sel_if sel ();

  // ****************************************
  // APB decode
  // ****************************************
  // Every answer comes with no wait state; ready is registered from the setup cycle so that read data can leave a flip-flop
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable & pready_r;
  wire hit_ctrl  = (paddr == ADDR_W'(`AIMC_CTRL_OFS));
  wire hit_lock  = (paddr == ADDR_W'(`AIMC_LOCK_OFS));
  wire hit_any   = hit_ctrl | hit_lock;
  wire wr_ctrl   = access_ph & pwrite & hit_ctrl;
  wire wr_lock   = access_ph & pwrite & hit_lock;
  wire lock_take = wr_lock & ~lock_used_r; // RL8

  // Locked writes still finish normally and leave the word alone
  assign amp_control_word_nxt = (wr_ctrl && !config_write_lock_r) // RL9 RL13
                              ? (pwdata & `AIMC_CTRL_WMASK)
                              : amp_control_word_r;

  // Read data and error are chosen in the setup cycle
  assign prdata_nxt  = !setup_ph ? prdata_r
                     : hit_ctrl  ? amp_control_word_r
                     : hit_lock  ? {31'h0000_0000, config_write_lock_r}
                     : 32'h0000_0000;
  assign pslverr_nxt = setup_ph & ~hit_any;

  // ****************************************
  // Bus registers
  // ****************************************
  // Ready generator and registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // Control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_control_word_r <= `AIMC_CTRL_RST;
    end else begin
      amp_control_word_r <= amp_control_word_nxt;
    end
  end

  // One-shot lock: the first write after reset decides, whatever value it carries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_write_lock_r <= `AIMC_LOCK_RST;
      lock_used_r         <= 1'b0;
    end else if (lock_take) begin
      config_write_lock_r <= pwdata[`AIMC_LOCK_BIT]; // RL8
      lock_used_r         <= 1'b1; // RL8
    end
  end

  // ****************************************
  // Timer compare synchroniser
  // ****************************************
  // The timer may run on another clock, so two stages before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc6_meta_r <= 1'b0;
      cc6_sync_r <= 1'b0;
    end else begin
      cc6_meta_r <= timer_compare6_signal;
      cc6_sync_r <= cc6_meta_r;
    end
  end

  // ****************************************
  // Field distribution
  // ****************************************
  assign sel.mode         = aimc_mode_t'(amp_control_word_r[`AIMC_MODE_MSB:`AIMC_MODE_LSB]); // RL7
  assign sel.gain_code    = amp_control_word_r[`AIMC_GAIN_MSB:`AIMC_GAIN_LSB]; // RL6
  assign sel.inv_sel      = amp_control_word_r[`AIMC_INV_MSB:`AIMC_INV_LSB]; // RL5
  assign sel.ninv_sel     = amp_control_word_r[`AIMC_NINV_MSB:`AIMC_NINV_LSB]; // RL4
  assign sel.auto_en      = amp_control_word_r[`AIMC_AUTO_BIT]; // RL3
  assign sel.alt_inv_sel  = amp_control_word_r[`AIMC_ALT_INV_MSB:`AIMC_ALT_INV_LSB]; // RL2
  assign sel.alt_ninv_sel = amp_control_word_r[`AIMC_ALT_NINV_MSB:`AIMC_ALT_NINV_LSB]; // RL1
  assign sel.cc6          = cc6_sync_r; // RL11

  aimc_input_mux u_mux (
    .sel (sel)
  );

  aimc_gain_decode u_gain (
    .sel (sel)
  );

  // ****************************************
  // Registered outputs
  // ****************************************
  // Analog controls are registered so that no decode glitch reaches the switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_enable        <= 1'b0;
      amp_mode          <= 2'b00;
      noninv_pin_onehot <= 7'h00;
      inv_pin_onehot    <= 4'h0;
      inv_to_output     <= 1'b0;
      gain_factor       <= 6'h00;
      amp_cfg_locked    <= 1'b0;
    end else begin
      amp_enable        <= amp_control_word_r[`AIMC_EN_BIT]; // RL13
      amp_mode          <= sel.mode;
      noninv_pin_onehot <= sel.ninv_onehot;
      inv_pin_onehot    <= sel.inv_onehot;
      inv_to_output     <= sel.inv_to_out; // RL12
      gain_factor       <= sel.gain_factor;
      amp_cfg_locked    <= config_write_lock_r;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************
  // Assertion arming
  // ****************************************
  // The edge that releases reset still sees reset values on every flop, so checks
  // start one edge later; otherwise an attempt begun there would fail falsely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_arm_r <= 1'b0;
    end else begin
      chk_arm_r <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !chk_arm_r);

  AST_ALT_NINV: assert property ( // RL1
    (amp_control_word_r[`AIMC_AUTO_BIT] && cc6_sync_r) |=>
      noninv_pin_onehot == aimc_ninv_onehot($past(amp_control_word_r[`AIMC_ALT_NINV_MSB:`AIMC_ALT_NINV_LSB])))
    else $error("secondary non-inverting selection not applied");

  AST_ALT_INV: assert property ( // RL2
    (amp_control_word_r[`AIMC_AUTO_BIT] && cc6_sync_r && !amp_control_word_r[`AIMC_MODE_MSB]) |=>
      inv_pin_onehot == aimc_inv_onehot($past(amp_control_word_r[`AIMC_ALT_INV_MSB:`AIMC_ALT_INV_LSB])))
    else $error("secondary inverting selection not applied");

  AST_PRIMARY_FIXED: assert property ( // RL3
    !amp_control_word_r[`AIMC_AUTO_BIT] |=>
      noninv_pin_onehot == aimc_ninv_onehot($past(amp_control_word_r[`AIMC_NINV_MSB:`AIMC_NINV_LSB])))
    else $error("primary selection not held with switching off");

  AST_NINV_CODE7: assert property ( // RL4
    (!(amp_control_word_r[`AIMC_AUTO_BIT] && cc6_sync_r) &&
     amp_control_word_r[`AIMC_NINV_MSB:`AIMC_NINV_LSB] == 3'h7) |=> noninv_pin_onehot == 7'h00)
    else $error("unused non-inverting code routed a pin");

  AST_GAIN: assert property ( // RL6
    ##1 gain_factor == (($past(sel.gain_code) <= 3'h4) ? 6'(6'h02 << $past(sel.gain_code)) : 6'h02))
    else $error("gain factor does not match code");

  AST_EXT_INV: assert property ( // RL7
    (amp_control_word_r[`AIMC_MODE_MSB] == 1'b0) |=> ($onehot(inv_pin_onehot) && !inv_to_output))
    else $error("external mode lacks one inverting pin");

  AST_LOCK_ONCE: assert property ( // RL8
    (lock_used_r && wr_lock) |=> $stable(config_write_lock_r))
    else $error("lock bit changed after its single write");

  AST_LOCKED_WRITE: assert property ( // RL9
    (config_write_lock_r && wr_ctrl) |=> $stable(amp_control_word_r))
    else $error("locked control word was written");

  AST_FOLLOW: assert property ( // RL12
    (sel.mode == AIMC_MODE_FOLLOW) |=> (inv_to_output && inv_pin_onehot == 4'h0))
    else $error("follower mode not tied to output");

  AST_NO_ERR_LOCKED: assert property ( // RL13
    (setup_ph && hit_ctrl) |=> (pready && !pslverr) ##1 !pready)
    else $error("control word access answered wrongly");

  AST_ENABLE: assert property ( // RL13
    amp_control_word_r[`AIMC_EN_BIT] |=> amp_enable)
    else $error("enable bit not passed to amplifier");

  AST_PRIMARY_CC6_LOW: assert property ( // RL11
    (amp_control_word_r[`AIMC_AUTO_BIT] && !cc6_sync_r) |=>
      noninv_pin_onehot == aimc_ninv_onehot($past(amp_control_word_r[`AIMC_NINV_MSB:`AIMC_NINV_LSB])))
    else $error("primary selection not applied with compare low");

  AST_PRIMARY_INV: assert property ( // RL5
    (!amp_control_word_r[`AIMC_AUTO_BIT] && !amp_control_word_r[`AIMC_MODE_MSB]) |=>
      inv_pin_onehot == aimc_inv_onehot($past(amp_control_word_r[`AIMC_INV_MSB:`AIMC_INV_LSB])))
    else $error("primary inverting selection not applied");

  AST_PGA_FLOAT: assert property ( // RL7
    (sel.mode == AIMC_MODE_PGA) |=> (inv_pin_onehot == 4'h0 && !inv_to_output))
    else $error("gain mode drives an inverting pin");

  AST_MODE_OUT: assert property ( // RL7
    1'b1 |=> amp_mode == $past(amp_control_word_r[`AIMC_MODE_MSB:`AIMC_MODE_LSB]))
    else $error("mode output does not follow the control word");

  AST_LOCK_FIRST: assert property ( // RL8
    lock_take |=> (lock_used_r && config_write_lock_r == $past(pwdata[`AIMC_LOCK_BIT])))
    else $error("first lock write not taken");

  AST_LOCK_READ: assert property ( // RL8
    (setup_ph && hit_lock && !pwrite) |=> prdata == {31'h0000_0000, $past(config_write_lock_r)})
    else $error("lock register read back wrongly");

  AST_UNLOCKED_WRITE: assert property ( // RL9
    (!config_write_lock_r && wr_ctrl) |=> amp_control_word_r == ($past(pwdata) & `AIMC_CTRL_WMASK))
    else $error("unlocked control word write lost");

  AST_CTRL_READ: assert property ( // RL9
    (setup_ph && hit_ctrl && !pwrite) |=> prdata == $past(amp_control_word_r))
    else $error("control word read back wrongly");

  AST_LOCK_MIRROR: assert property ( // RL9
    1'b1 |=> amp_cfg_locked == $past(config_write_lock_r))
    else $error("lock output does not follow the lock bit");

  AST_UNMAPPED: assert property ( // RL13
    (setup_ph && !hit_any) |=> (pready && pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  COV_LOCK: cover property (lock_take && pwdata[0]);
  COV_LOCKED_WR: cover property (config_write_lock_r && wr_ctrl);
  COV_SWITCH: cover property (sel.auto_en && $rose(cc6_sync_r));
  COV_FOLLOW: cover property (inv_to_output && amp_enable);
  COV_UNMAPPED: cover property (setup_ph && !hit_any);

endmodule
`default_nettype wire

/* verilog/aimc_params.svh */
// Register offsets, field positions, reset values and masks of the amplifier register bank
`ifndef AIMC_PARAMS_SVH
`define AIMC_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define AIMC_CTRL_OFS      12'h000
`define AIMC_LOCK_OFS      12'h004

// ****************************************
// Control word field positions
// ****************************************
`define AIMC_EN_BIT        0
`define AIMC_MODE_LSB      1
`define AIMC_MODE_MSB      2
`define AIMC_GAIN_LSB      3
`define AIMC_GAIN_MSB      5
`define AIMC_INV_LSB       6
`define AIMC_INV_MSB       7
`define AIMC_NINV_LSB      9
`define AIMC_NINV_MSB      11
`define AIMC_AUTO_BIT      13
`define AIMC_ALT_INV_LSB   14
`define AIMC_ALT_INV_MSB   15
`define AIMC_ALT_NINV_LSB  17
`define AIMC_ALT_NINV_MSB  19
`define AIMC_LOCK_BIT      0

// ****************************************
// Reset values and writable bits
// ****************************************
`define AIMC_CTRL_RST      32'h0000_0000
`define AIMC_LOCK_RST      1'b0
`define AIMC_CTRL_WMASK    32'h000E_EEFF
`define AIMC_GAIN_MAX_CODE 3'h4
`define AIMC_GAIN_BASE     6'h02

`endif

/* verilog/aimc_pkg.sv */
// Types and shared decode functions of the amplifier register bank
package aimc_pkg;

  // ****************************************
  // Working modes of the amplifier
  // ****************************************
  typedef enum logic [1:0] {
    AIMC_MODE_EXT_A  = 2'b00,
    AIMC_MODE_EXT_B  = 2'b01,
    AIMC_MODE_PGA    = 2'b10,
    AIMC_MODE_FOLLOW = 2'b11
  } aimc_mode_t;

  // Non-inverting select code to one-hot pin enables; code 7 routes no pin
  function automatic logic [6:0] aimc_ninv_onehot(input logic [2:0] code);
    logic [6:0] v;
    v = 7'h00;
    if (code != 3'h7) begin
      v[code] = 1'b1;
    end
    return v;
  endfunction

  // Inverting select code to one-hot pin enables
  function automatic logic [3:0] aimc_inv_onehot(input logic [1:0] code);
    logic [3:0] v;
    v = 4'h0;
    v[code] = 1'b1;
    return v;
  endfunction

endpackage

/* verilog/aimc_sel_if.sv */
// Bundle between the register bank and its input routing and gain decoding
`timescale 1ns/1ns
`default_nettype none
interface aimc_sel_if;
  import aimc_pkg::*;
  aimc_mode_t  mode;
  logic [2:0]  gain_code;
  logic [2:0]  ninv_sel;
  logic [1:0]  inv_sel;
  logic [2:0]  alt_ninv_sel;
  logic [1:0]  alt_inv_sel;
  logic        auto_en;
  logic        cc6;
  logic [6:0]  ninv_onehot;
  logic [3:0]  inv_onehot;
  logic        inv_to_out;
  logic [5:0]  gain_factor;

  modport ctrl (output mode, gain_code, ninv_sel, inv_sel, alt_ninv_sel, alt_inv_sel, auto_en, cc6,
                input ninv_onehot, inv_onehot, inv_to_out, gain_factor);
  modport mux  (input mode, ninv_sel, inv_sel, alt_ninv_sel, alt_inv_sel, auto_en, cc6,
                output ninv_onehot, inv_onehot, inv_to_out);
  modport gain (input gain_code, output gain_factor);
endinterface
`default_nettype wire

/* verilog/aimc_input_mux.sv */
// Primary/secondary input routing of the amplifier
`timescale 1ns/1ns
`default_nettype none
module aimc_input_mux
  import aimc_pkg::*;
(
  aimc_sel_if.mux sel
);

  // ****************************************
  // Selection source
  // ****************************************
  wire       use_alt = sel.auto_en & sel.cc6; // RL3 RL11
  wire [2:0] ninv_code = use_alt ? sel.alt_ninv_sel : sel.ninv_sel; // RL1 RL4
  wire [1:0] inv_code  = use_alt ? sel.alt_inv_sel : sel.inv_sel; // RL2 RL5
  wire       is_ext    = (sel.mode == AIMC_MODE_EXT_A) || (sel.mode == AIMC_MODE_EXT_B); // RL7

  // Inverting pin only in external mode; PGA leaves it floating, follower ties it to the output
  assign sel.ninv_onehot = aimc_ninv_onehot(ninv_code); // RL4
  assign sel.inv_onehot  = is_ext ? aimc_inv_onehot(inv_code) : 4'h0; // RL5
  assign sel.inv_to_out  = (sel.mode == AIMC_MODE_FOLLOW); // RL12

endmodule
`default_nettype wire

/* verilog/aimc_gain_decode.sv */
// Internal gain step decode of the amplifier
`timescale 1ns/1ns
`default_nettype none
`include "aimc_params.svh"
module aimc_gain_decode
  import aimc_pkg::*;
(
  aimc_sel_if.gain sel
);

  // ****************************************
  // Gain factor
  // ****************************************
  // Codes above the largest step fall back to the base gain
  wire in_range = (sel.gain_code <= `AIMC_GAIN_MAX_CODE);
  assign sel.gain_factor = in_range ? 6'(`AIMC_GAIN_BASE << sel.gain_code) : `AIMC_GAIN_BASE; // RL6

endmodule
`default_nettype wire

/* tb/amp_input_mux_control_tb_top.sv */
// Self-checking bench for the amplifier register bank
`timescale 1ns/1ns
`default_nettype none
`include "aimc_params.svh"
module amp_input_mux_control_tb_top
  import aimc_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic        pclk    = 1'h0;
  logic        presetn = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        tcc6    = 1'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        amp_enable;
  logic [1:0]  amp_mode;
  logic [6:0]  ninv_oh;
  logic [3:0]  inv_oh;
  logic        inv_out;
  logic [5:0]  gain;
  logic        locked;
  logic [31:0] rng     = 32'h0000_0049;
  logic [31:0] v;
  logic [33:0] ent;
  logic [33:0] expq[$];
  int          mismatches = 0;
  int          checks     = 0;

  // 20 MHz bus clock
  always #25 pclk = ~pclk;

  aimc_top u_aimc_top (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .timer_compare6_signal (tcc6),
    .amp_enable            (amp_enable),
    .amp_mode              (amp_mode),
    .noninv_pin_onehot     (ninv_oh),
    .inv_pin_onehot        (inv_oh),
    .inv_to_output         (inv_out),
    .gain_factor           (gain),
    .amp_cfg_locked        (locked)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    int n;
    expq.push_back({~wr, err, exp});
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      mismatches++;
      tally_and_finish();
    end else begin
      psel    <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  // Pin outputs worked out from the stored word and the timer level
  task automatic pins(input logic [31:0] w);
    logic       alt;
    logic [2:0] nc;
    logic [1:0] ic;
    // Two sync stages and the output register; the timer level may have been set this very step
    repeat (4) @(posedge pclk);
    alt = w[13] & tcc6;
    nc  = alt ? w[19:17] : w[11:9];
    ic  = alt ? w[15:14] : w[7:6];
    check(32'(amp_enable), 32'(w[0]));
    check(32'(amp_mode), 32'(w[2:1]));
    check(32'(gain), 32'(w[5:3] <= 3'h4 ? 6'h02 << w[5:3] : 6'h02));
    check(32'(ninv_oh), (nc == 3'h7) ? 32'h0000_0000 : 32'h0000_0001 << nc);
    check(32'(inv_oh), 32'(w[2] ? 4'h0 : 4'h1 << ic));
    check(32'(inv_out), 32'(w[2:1] == 2'h3));
  endtask

  // Monitor: each completed transfer takes the oldest queued answer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1) begin
      if (expq.size() == 0) begin
        ent = 34'h0_0000_0000;
        mismatches++;
      end else begin
        ent = expq.pop_front();
      end
      check(32'(pslverr), 32'(ent[32]));
      if (ent[33]) begin
        check(prdata, ent[31:0]);
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values and unmapped places
    apb(1'h0, `AIMC_CTRL_OFS, 32'h0, 32'h0, 1'h0);
    apb(1'h0, `AIMC_LOCK_OFS, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 12'h008, 32'h0, 32'h0, 1'h1);
    apb(1'h1, 12'h00C, 32'h5, 32'h0, 1'h1);
    pins(32'h0);
    // Every gain and mode code, random selections and timer level
    for (int i = 0; i < 16; i++) begin
      v = xs() & `AIMC_CTRL_WMASK;
      v[5:1] = {i[2:0], i[3:2]};
      tcc6 <= 1'(xs() >> 31);
      apb(1'h1, `AIMC_CTRL_OFS, v, 32'h0, 1'h0);
      apb(1'h0, `AIMC_CTRL_OFS, 32'h0, v, 1'h0);
      pins(v);
    end
    // Timer toggling with switching on
    v = 32'h0006_AA40;
    apb(1'h1, `AIMC_CTRL_OFS, v, 32'h0, 1'h0);
    for (int k = 0; k < 4; k++) begin
      tcc6 <= ~k[0];
      pins(v);
    end
    // Lock, then a locked control write and a second lock write
    apb(1'h1, `AIMC_LOCK_OFS, 32'h1, 32'h0, 1'h0);
    apb(1'h0, `AIMC_LOCK_OFS, 32'h0, 32'h1, 1'h0);
    check(32'(locked), 32'h1);
    apb(1'h1, `AIMC_CTRL_OFS, 32'h0000_0003, 32'h0, 1'h0);
    apb(1'h0, `AIMC_CTRL_OFS, 32'h0, v, 1'h0);
    apb(1'h1, `AIMC_LOCK_OFS, 32'h0, 32'h0, 1'h0);
    apb(1'h0, `AIMC_LOCK_OFS, 32'h0, 32'h1, 1'h0);
    pins(v);
    // Second reset: a zero write uses up the one-shot
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h1, `AIMC_LOCK_OFS, 32'h0, 32'h0, 1'h0);
    apb(1'h1, `AIMC_LOCK_OFS, 32'h1, 32'h0, 1'h0);
    apb(1'h0, `AIMC_LOCK_OFS, 32'h0, 32'h0, 1'h0);
    apb(1'h1, `AIMC_CTRL_OFS, 32'h0000_0005, 32'h0, 1'h0);
    apb(1'h0, `AIMC_CTRL_OFS, 32'h0, 32'h0000_0005, 1'h0);
    check(32'(locked), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
